//--- src/fcw_pkg.sv
// Constants shared by the frame clocked watchdog.
package fcw_pkg;
  localparam int          FRAME_RATE_HZ  = 8000;
  localparam int          TIMEOUT_MS     = 512;
  localparam int          TIMEOUT_FRAMES = TIMEOUT_MS * FRAME_RATE_HZ / 1000;
  localparam int          BYTE_BITS      = 8;
  localparam int          ADDR_W         = 6;
  localparam int          RW_BIT         = 7;
  localparam int          WORD_W         = 5;
  localparam logic [5:0]  WDOG_ADDR      = 6'h11;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  localparam logic [2:0]  BIT_ZERO       = 3'h0;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [4:0]  RESET_WORD_DEF = 5'h15;

  typedef enum logic [3:0] {
    FCW_SP_IDLE = 4'h1,
    FCW_SP_CMD  = 4'h2,
    FCW_SP_DATA = 4'h4,
    FCW_SP_WAIT = 4'h8
  } fcw_sp_state_t;
endpackage

//--- src/fcw_watchdog.sv
// Watchdog timer clocked by frame pulse edges, serviced over the serial microport.
// Function
// - Output high while power-on reset held.
// - Reset release returns output low immediately.
// - Reset release starts timer from zero.
// - Timer advances only on frame falling edges.
// - Correct word before timeout restarts timer.
// - Output low while correct writes keep coming.
// - Missing or wrong word raises output.
// - After timeout output toggles each period.
// - Only five data bits are compared.
// - Write is command byte then data byte.
`timescale 1ns/1ps
module fcw_watchdog
  import fcw_pkg::*;
#(
  parameter int         TIMEOUT_COUNT = TIMEOUT_FRAMES,
  parameter logic [4:0] RESET_WORD    = RESET_WORD_DEF
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic power_on_reset_in,
  input  wire logic frame_pulse_in,
  input  wire logic serial_clk_in,
  input  wire logic chip_select_n_in,
  input  wire logic serial_port_data_in,
  output logic      serial_port_data_out,
  output logic      serial_port_data_oe,
  output logic      watchdog_out
);
  localparam int CW = $clog2(TIMEOUT_COUNT);
  localparam logic [CW-1:0] CNT_MAX  = CW'(TIMEOUT_COUNT - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  // Two-stage synchronisers; only stage [1] is read by logic.
  logic [1:0] por_s;
  logic [1:0] frm_s;
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] dat_s;
  logic       por_d;
  logic       frm_d;
  logic       sclk_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      por_s  <= 2'h3;
      frm_s  <= 2'h3;
      sclk_s <= 2'h3;
      cs_s   <= 2'h3;
      dat_s  <= 2'h0;
      por_d  <= 1'b1;
      frm_d  <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      por_s  <= {por_s[0], power_on_reset_in};
      frm_s  <= {frm_s[0], frame_pulse_in};
      sclk_s <= {sclk_s[0], serial_clk_in};
      cs_s   <= {cs_s[0], chip_select_n_in};
      dat_s  <= {dat_s[0], serial_port_data_in};
      por_d  <= por_s[1];
      frm_d  <= frm_s[1];
      sclk_d <= sclk_s[1];
    end
  end

  // The timer hears only the frame pulse, so a stalled serial clock cannot
  // hold it back.
  logic frame_fall;
  logic sclk_fall;
  logic por_on;
  logic por_release;
  assign frame_fall  = frm_d & ~frm_s[1];
  assign sclk_fall   = sclk_d & ~sclk_s[1];
  assign por_on      = por_s[1];
  assign por_release = por_d & ~por_s[1];

  // Serial receive: LSB first, sampled on the falling serial clock edge.
  fcw_sp_state_t sp_state;
  logic [2:0]    bit_cnt;
  logic [7:0]    shreg;
  logic          cmd_ok;
  logic          svc_ok;
  logic [7:0]    byte_now;
  logic          byte_done;
  logic          data_done;
  logic          word_match;

  assign byte_now   = {dat_s[1], shreg[7:1]};
  assign byte_done  = sclk_fall & ~cs_s[1] & (bit_cnt == BIT_LAST);
  assign data_done  = byte_done & (sp_state == FCW_SP_DATA);
  assign word_match = byte_now[WORD_W-1:0] == RESET_WORD;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_state <= FCW_SP_IDLE;
      bit_cnt  <= BIT_ZERO;
      shreg    <= BYTE_ZERO;
      cmd_ok   <= 1'b0;
    end else if (cs_s[1]) begin
      // A transfer cut short by chip select rising is discarded.
      sp_state <= FCW_SP_IDLE;
      bit_cnt  <= BIT_ZERO;
    end else begin
      case (sp_state)
        FCW_SP_IDLE: begin
          sp_state <= FCW_SP_CMD;
          bit_cnt  <= BIT_ZERO;
        end
        FCW_SP_CMD: begin
          if (sclk_fall) begin
            shreg   <= byte_now;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              sp_state <= FCW_SP_DATA;
              cmd_ok   <= ~byte_now[RW_BIT] & (byte_now[ADDR_W-1:0] == WDOG_ADDR);
            end
          end
        end
        FCW_SP_DATA: begin
          if (sclk_fall) begin
            shreg   <= byte_now;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              sp_state <= FCW_SP_WAIT;
            end
          end
        end
        FCW_SP_WAIT: sp_state <= FCW_SP_WAIT;
        default:     sp_state <= FCW_SP_IDLE;
      endcase
    end
  end

  // A one-cycle service strobe keeps the timer and the output in step.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      svc_ok <= 1'b0;
    end else begin
      svc_ok <= data_done & cmd_ok & word_match;
    end
  end

  // Timeout counter over frame edges; held clear while power-on reset is on.
  logic [CW-1:0] tcnt;
  logic          expire;
  assign expire = frame_fall & (tcnt == CNT_MAX) & ~por_on & ~por_d & ~svc_ok;

  always_ff @(posedge clk) begin
    if (sys_rst || por_on) begin
      tcnt <= CNT_ZERO;
    end else if (svc_ok) begin
      tcnt <= CNT_ZERO;
    end else if (frame_fall) begin
      tcnt <= (tcnt == CNT_MAX) ? CNT_ZERO : tcnt + CNT_ONE;
    end
  end

  // A wrong word does not restart the counter, so the output still rises at the
  // end of the running interval rather than at once.
  always_ff @(posedge clk) begin
    if (sys_rst || por_on) begin
      watchdog_out <= 1'b1;
    end else if (por_release || svc_ok) begin
      watchdog_out <= 1'b0;
    end else if (expire) begin
      watchdog_out <= ~watchdog_out;
    end
  end

  // The only register here is write-only, so the data pin is never driven.
  always_ff @(posedge clk) begin
    serial_port_data_out <= 1'b0;
    serial_port_data_oe  <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  por_high_a: assert property (por_on |=> watchdog_out)
    else $error("watchdog output not high during power-on reset");
  por_release_a: assert property ($fell(por_on) |=> !watchdog_out)
    else $error("watchdog output not low after reset release");
  timer_start_a: assert property ($fell(por_on) |-> tcnt == CNT_ZERO)
    else $error("timer not zero at reset release");
  count_edge_a: assert property (!por_on && !svc_ok && !frame_fall |=> $stable(tcnt))
    else $error("timer moved without a frame edge");
  // Power-on reset outranks a service that lands in the same cycle, so that case
  // is left to por_high_a.
  service_clear_a: assert property (svc_ok && !por_on
                                    |=> tcnt == CNT_ZERO && !watchdog_out)
    else $error("correct word did not restart timer");
  wd_hold_a: assert property (!expire && !svc_ok && !por_on && !por_d
                              |=> $stable(watchdog_out))
    else $error("watchdog output changed without cause");
  expire_toggle_a: assert property (expire |=> watchdog_out != $past(watchdog_out))
    else $error("watchdog output did not toggle at timeout");
  expire_high_a: assert property (expire && !watchdog_out |=> watchdog_out)
    else $error("watchdog output not raised at timeout");
  word_check_a: assert property (data_done && cmd_ok && word_match |=> svc_ok)
    else $error("correct reset word not accepted");
  two_byte_a: assert property (svc_ok |-> $past(sp_state) == FCW_SP_DATA)
    else $error("service without a data byte");
  period_a: assert property (frame_fall && !por_on && !svc_ok && tcnt != CNT_MAX
                             |=> tcnt == $past(tcnt) + CNT_ONE)
    else $error("timer did not advance on frame edge");
  por_timer_a: assert property (por_on |=> tcnt == CNT_ZERO)
    else $error("timer not held clear during power-on reset");
  expire_wrap_a: assert property (expire |=> tcnt == CNT_ZERO)
    else $error("timer did not wrap at timeout");
  word_miss_a: assert property (data_done && !word_match |=> !svc_ok)
    else $error("wrong reset word accepted");
  svc_once_a: assert property (svc_ok |=> !svc_ok)
    else $error("one transfer serviced the timer twice");
  // A raised chip select must discard whatever part of a transfer is in flight.
  cut_frame_a: assert property (cs_s[1] |=> !svc_ok)
    else $error("service taken from a cut transfer");
  data_quiet_a: assert property (!serial_port_data_oe)
    else $error("data pin driven for a write-only register");
endmodule  // fcw_watchdog

//--- tb/fcw_host.sv
// Host microcontroller model that drives the serial microport.
`timescale 1ns/1ps
module fcw_host (
  output logic sclk,
  output logic cs_n,
  output logic sdo
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdo  = 1'b0;
  end
  // The clock stands high between frames; data moves after each rising edge.
  // Fewer than 16 bits makes a transfer that chip select cuts short.
  task automatic write(input logic [7:0] cmd, input logic [7:0] dat,
                       input int nbits);
    logic [15:0] bits;
    bits = {dat, cmd};
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdo = bits[i];
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
    #40 cs_n = 1'b1;
    // A released line must not keep showing the last bit.
    sdo = ~sdo;
    #100;
  endtask
endmodule // fcw_host

//--- tb/fcw_watchdog_tb.sv
// Self-checking bench for the frame clocked watchdog.
`timescale 1ns/1ps
module fcw_watchdog_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_on_reset_in = 1'b1;
  logic frame_pulse_in = 1'b1;
  logic sclk, cs_n, sdo, data_out, data_oe, watchdog_out;
  int   error_cnt = 0;
  int   checked = 0;
  int   cycles = 0;
  // Row: command, data byte, frame edges, expected output.
  localparam logic [20:0] ROWS [8] = '{
    {8'h00, 8'h15, 4'h7, 1'b0},
    {8'h51, 8'hF5, 4'h7, 1'b0},
    {8'h11, 8'h15, 4'h7, 1'b0},
    {8'h11, 8'h14, 4'h1, 1'b1},
    {8'h91, 8'h15, 4'h8, 1'b0},
    {8'h12, 8'h15, 4'h8, 1'b1},
    {8'h11, 8'h35, 4'h0, 1'b0},
    {8'h00, 8'h15, 4'h8, 1'b1}
  };
  always #5 clk = ~clk;
  fcw_host host (.sclk(sclk), .cs_n(cs_n), .sdo(sdo));
  fcw_watchdog #(.TIMEOUT_COUNT(8)) dut (
    .clk(clk), .sys_rst(sys_rst), .power_on_reset_in(power_on_reset_in),
    .frame_pulse_in(frame_pulse_in), .serial_clk_in(sclk), .chip_select_n_in(cs_n),
    .serial_port_data_in(sdo), .serial_port_data_out(data_out),
    .serial_port_data_oe(data_oe), .watchdog_out(watchdog_out));
  task automatic check(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: output %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clk) frame_pulse_in <= 1'b0;
      repeat (3) @(negedge clk);
      frame_pulse_in <= 1'b1;
      repeat (3) @(negedge clk);
    end
    repeat (6) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The rows need about 2200 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    check(watchdog_out, 1'b1);
    power_on_reset_in = 1'b0;
    repeat (5) @(negedge clk);
    check(watchdog_out, 1'b0);
    check(data_oe, 1'b0);
    check(data_out, 1'b0);
    foreach (ROWS[i]) begin
      host.write(ROWS[i][20:13], ROWS[i][12:5], 16);
      repeat (10) @(negedge clk);
      frames(int'(ROWS[i][4:1]));
      check(watchdog_out, ROWS[i][0]);
    end
    power_on_reset_in = 1'b1;
    frames(3);
    check(watchdog_out, 1'b1);
    power_on_reset_in = 1'b0;
    repeat (5) @(negedge clk);
    check(watchdog_out, 1'b0);
    frames(7);
    check(watchdog_out, 1'b0);
    frames(1);
    check(watchdog_out, 1'b1);
    host.write(8'h11, 8'h15, 12);
    frames(1);
    check(watchdog_out, 1'b1);
    host.write(8'h11, 8'h15, 16);
    repeat (10) @(negedge clk);
    check(watchdog_out, 1'b0);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    check(watchdog_out, 1'b1);
    check(data_oe, 1'b0);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk);
    check(watchdog_out, 1'b0);
    check(data_out, 1'b0);
    complete_run();
  end
endmodule // fcw_watchdog_tb
